// ==== rtl/erxic_fifo.sv ====
// Receive data FIFO with flush
`timescale 1ns/10ps
module erxic_fifo #(
  parameter int WIDTH = erxic_pkg::FIFO_W,
  parameter int DEPTH = erxic_pkg::FIFO_D
) (
  // Clock and reset
  input logic mclk,
  input logic srst,
  input logic flush,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && !full && !flush;
  assign pop = out_valid && out_ready && !flush;

  // Pointers
  always_ff @(posedge mclk) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Storage entries
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge mclk) begin
      if (push && wr_ptr[AW-1:0] == AW'(i)) begin
        mem[i] <= in_data;
      end
    end
  end
endmodule

// ==== rtl/erxic_pkg.sv ====
// Constants and types shared by the receive and interrupt control block
package erxic_pkg;
  localparam int FIFO_W = 36;
  localparam int FIFO_D = 16;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  localparam logic [15:0] DEST_BYTES = 16'h0006;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
  localparam logic [31:0] DESC_STRIDE = 32'h00000010;
  localparam logic [11:0] WORD_BYTES = 12'h004;
  localparam logic [1:0] WIDX_CTL = 2'h1;
  localparam logic [1:0] WIDX_BUF = 2'h2;
  localparam logic [1:0] WIDX_NEXT = 2'h3;
  localparam int DW0_OWN = 31;
  localparam int DW0_LEN_LSB = 16;
  localparam int DW0_LEN_W = 15;
  localparam int DW0_ES = 15;
  localparam int DW0_TN = 14;
  localparam int DW0_FS = 9;
  localparam int DW0_LS = 8;
  localparam int DW1_CA = 24;
  localparam int DW1_SIZE_W = 11;
  localparam int FW_NB_LSB = 32;
  localparam int FW_LAST = 34;
  localparam int FW_BAD = 35;
  localparam int ST_RI = 0;
  localparam int ST_RU = 1;
  localparam int ST_BF = 2;
  localparam int ST_TI = 3;
  localparam int ST_W = 4;
  localparam logic [1:0] FM_NORMAL = 2'h0;
  localparam logic [1:0] FM_PROMISC = 2'h1;
  localparam logic [1:0] FM_ALL_MCAST = 2'h2;
  localparam logic [1:0] RXS_STOPPED = 2'h0;
  localparam logic [1:0] RXS_RUNNING = 2'h1;
  localparam logic [1:0] RXS_SUSPENDED = 2'h2;
  localparam logic [15:0] MFC_MAX = 16'hFFFF;
  typedef enum logic [2:0] {RX_STOPPED, RX_IDLE, RX_FETCH, RX_WRITE, RX_CLOSE, RX_SUSPENDED} erxic_state_type;
endpackage

// ==== rtl/erxic_top.sv ====
// Receive process, descriptor handling and interrupt request logic
// Operation
// - Interrupt sources live in the status register; requests only while interrupt enable set.
// - Writing one clears a status bit; cleared bit may interrupt again later.
// - No queued interrupts; repeats or simultaneous events give one request.
// - Clearing all set bits before acknowledge withdraws the pending request.
// - Receive starts and stops by its own command, independent of transmit.
// - Receiver always tries to hold one extra acquired descriptor.
// - Strip preamble, buffer frame in FIFO, purge frames failing address filter.
// - Frames under 64 bytes are purged unless pass bad frames is set.
// - Buffer transfer of a frame starts only after 64 bytes received, or at frame end for a kept shorter frame.
// - With chaining enabled, overflow continues into next buffers; first/last flags marked.
// - Descriptor ownership returns to host when buffer full or frame ends.
// - Last descriptor gets last flag and status; then receive done flag sets.
// - At host-owned descriptor, fill acquired buffers, set unavailable flag, suspend.
// - Suspended: each frame refetches descriptor; resume if owned, else count miss.
// - Start from stopped resumes saved position, or list head if first/rewritten.
// - Stop while running waits for frame end; stop while suspended is immediate.
// - Bus or parity error while running cuts off, sets bus fault, stops.
// - Poll demand or frame with descriptor resumes running from saved or head.
`timescale 1ns/10ps
module erxic_top (
  // Clock and reset
  input logic mclk,
  input logic srst,
  // Operating mode
  input logic interrupt_enable_bit,
  input logic start_reception,
  input logic [1:0] filter_mode_field,
  input logic hash_filter_select,
  input logic pass_bad_frames,
  input logic chaining_disable,
  // Receive list control
  input logic [31:0] rx_list_base,
  input logic rx_list_base_wr,
  input logic rx_poll_demand,
  // Filtering table
  input logic [47:0] station_addr,
  input logic [511:0] mcast_hash_table,
  // Status and interrupt
  input logic [erxic_pkg::ST_W-1:0] status_clear,
  input logic tx_done_event,
  input logic irq_ack,
  output logic [erxic_pkg::ST_W-1:0] status_interrupt_register,
  output logic irq_req,
  output logic [1:0] rx_state,
  output logic [15:0] missed_frame_count,
  // Receive link
  input logic rx_valid,
  input logic [7:0] rx_data,
  input logic rx_end,
  input logic rx_err,
  // Host memory
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input logic [31:0] mem_rdata,
  input logic mem_ack,
  input logic mem_err,
  input logic mem_xlate_err
);
  erxic_pkg::erxic_state_type state;
  // Front end
  logic in_frame;
  logic dropping;
  logic [15:0] fcnt;
  logic [47:0] dest;
  logic [31:0] crc;
  logic [1:0] lane;
  logic [31:0] wbuf;
  logic [31:0] wfill;
  logic filt_done;
  logic ovf;
  logic wq_valid;
  logic [erxic_pkg::FIFO_W-1:0] wq_word;
  logic end_pend;
  logic [erxic_pkg::FIFO_W-1:0] tail_word;
  logic fe_release;
  logic fe_flush;
  logic fe_sof;
  logic fe_ok;
  logic addr_ok;
  logic runt;
  logic bad_now;
  logic frame_busy;
  // FIFO
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [erxic_pkg::FIFO_W-1:0] fifo_out;
  logic wq_take;
  // Descriptor engine
  logic [31:0] list_pos;
  logic list_end;
  logic started;
  logic base_dirty;
  logic probe;
  logic discard;
  logic first_seg;
  logic [1:0] widx;
  logic [1:0] v;
  logic [31:0] d_addr [2];
  logic [31:0] d_buf [2];
  logic [10:0] d_size [2];
  logic [10:0] f_size;
  logic f_ca;
  logic [31:0] f_buf;
  logic f_tn;
  logic [11:0] boff;
  logic [14:0] flen;
  logic [31:0] close_addr;
  logic close_ls;
  logic close_bad;
  logic close_tn;
  logic close_trunc;
  logic [31:0] close_word;
  logic [31:0] resume_pos;
  logic [2:0] fnb;
  // Events
  logic ev_rx_done;
  logic ev_ru;
  logic ev_bf;
  logic ev_missed;
  logic fsm_drop;
  logic [erxic_pkg::ST_W-1:0] signalled;
  logic [erxic_pkg::ST_W-1:0] set_ev;
  logic [erxic_pkg::ST_W-1:0] next_status;
  logic [erxic_pkg::ST_W-1:0] next_signalled;

  // Hash register step over one byte, low bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r << 1) ^ ((r[31] ^ d[i]) ? erxic_pkg::CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // Address filter decision
  always_comb begin
    addr_ok = 1'b0;
    case (filter_mode_field)
      erxic_pkg::FM_PROMISC: addr_ok = 1'b1;
      erxic_pkg::FM_ALL_MCAST: addr_ok = dest[0] || dest == station_addr;
      erxic_pkg::FM_NORMAL: begin
        if (dest == erxic_pkg::BCAST_ADDR) begin
          addr_ok = 1'b1;
        end else if (dest[0]) begin
          addr_ok = hash_filter_select && mcast_hash_table[crc[31:23]];
        end else begin
          addr_ok = dest == station_addr;
        end
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    wfill = wbuf;
    wfill[{lane, 3'b000} +: 8] = rx_data;
  end

  assign runt = (fcnt + 16'h0001) < erxic_pkg::MIN_FRAME_BYTES;
  assign bad_now = rx_err || ovf || runt;
  assign fe_ok = state != erxic_pkg::RX_STOPPED && start_reception && !fifo_valid && !wq_valid && !end_pend
                 && !fe_release;
  assign frame_busy = (in_frame && !dropping) || fifo_valid || wq_valid || end_pend;
  assign wq_take = wq_valid && fifo_in_ready;

  // Link front end: strip preamble, pack words, filter and purge
  always_ff @(posedge mclk) begin
    fe_flush <= 1'b0;
    fe_sof <= 1'b0;
    if (wq_take) begin
      wq_valid <= 1'b0;
    end
    if (fifo_pop && fifo_out[erxic_pkg::FW_LAST]) begin
      fe_release <= 1'b0;
    end
    if (end_pend && (!wq_valid || wq_take)) begin
      wq_word <= tail_word;
      wq_valid <= 1'b1;
      end_pend <= 1'b0;
    end
    if (srst) begin
      in_frame <= 1'b0;
      dropping <= 1'b0;
      fcnt <= 16'h0000;
      dest <= 48'h000000000000;
      crc <= erxic_pkg::CRC_INIT;
      lane <= 2'h0;
      wbuf <= 32'h00000000;
      filt_done <= 1'b0;
      ovf <= 1'b0;
      wq_valid <= 1'b0;
      wq_word <= '0;
      end_pend <= 1'b0;
      tail_word <= '0;
      fe_release <= 1'b0;
    end else if (fsm_drop) begin
      in_frame <= in_frame && !(rx_valid && rx_end);
      dropping <= 1'b1;
      wq_valid <= 1'b0;
      end_pend <= 1'b0;
      fe_release <= 1'b0;
    end else if (!in_frame) begin
      if (rx_valid && rx_data == erxic_pkg::SFD_BYTE) begin
        in_frame <= 1'b1;
        dropping <= !fe_ok;
        fe_sof <= fe_ok;
        fcnt <= 16'h0000;
        lane <= 2'h0;
        filt_done <= 1'b0;
        ovf <= 1'b0;
        crc <= erxic_pkg::CRC_INIT;
      end
    end else begin
      if (rx_valid) begin
        if (rx_end) begin
          in_frame <= 1'b0;
        end
        if (!dropping) begin
          fcnt <= fcnt + 16'h0001;
          lane <= lane + 2'h1;
          wbuf <= wfill;
          if (fcnt < erxic_pkg::DEST_BYTES) begin
            dest[{fcnt[2:0], 3'b000} +: 8] <= rx_data;
            crc <= crc_byte(crc, rx_data);
          end
          if (lane == 2'h3 || rx_end) begin
            if (wq_valid && !wq_take) begin
              if (rx_end) begin
                tail_word <= {bad_now, 1'b1, lane, wfill};
                end_pend <= 1'b1;
              end else begin
                ovf <= 1'b1;
              end
            end else begin
              wq_word <= {bad_now, rx_end, lane, wfill};
              wq_valid <= 1'b1;
            end
          end
          if (rx_end) begin
            if (!filt_done || (runt && !pass_bad_frames)) begin
              fe_flush <= 1'b1;
              wq_valid <= 1'b0;
              end_pend <= 1'b0;
            end else begin
              fe_release <= 1'b1;
            end
          end else if (filt_done && fcnt >= erxic_pkg::MIN_FRAME_BYTES - 16'h0001) begin
            fe_release <= 1'b1;
          end
        end
      end
      if (!dropping && !filt_done && fcnt == erxic_pkg::DEST_BYTES) begin
        filt_done <= 1'b1;
        if (!addr_ok) begin
          dropping <= 1'b1;
          fe_flush <= 1'b1;
          wq_valid <= 1'b0;
        end
      end
    end
  end

  erxic_fifo #(
    .WIDTH(erxic_pkg::FIFO_W),
    .DEPTH(erxic_pkg::FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .flush(fe_flush || fsm_drop),
    .in_valid(wq_valid),
    .in_ready(fifo_in_ready),
    .in_data(wq_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  assign fifo_pop = (state == erxic_pkg::RX_WRITE && mem_req && mem_ack && !mem_err)
                    || (state == erxic_pkg::RX_IDLE && discard && fifo_valid && fe_release);
  assign resume_pos = v[0] ? d_addr[0] : list_pos;
  assign fnb = {1'b0, fifo_out[erxic_pkg::FW_NB_LSB +: 2]} + 3'h1;

  // Descriptor status word written back on release
  always_comb begin
    close_word = 32'h00000000;
    close_word[erxic_pkg::DW0_TN] = close_tn;
    close_word[erxic_pkg::DW0_ES] = close_bad || close_tn;
    if (!close_tn) begin
      close_word[erxic_pkg::DW0_FS] = first_seg;
      close_word[erxic_pkg::DW0_LS] = close_ls;
      if (close_ls) begin
        close_word[erxic_pkg::DW0_LEN_LSB +: erxic_pkg::DW0_LEN_W] = flen;
      end
    end
  end

  // Receive process state machine and host memory access
  always_ff @(posedge mclk) begin
    ev_rx_done <= 1'b0;
    ev_ru <= 1'b0;
    ev_bf <= 1'b0;
    ev_missed <= 1'b0;
    fsm_drop <= 1'b0;
    if (rx_list_base_wr) begin
      base_dirty <= 1'b1;
    end
    if (srst) begin
      state <= erxic_pkg::RX_STOPPED;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      list_pos <= 32'h00000000;
      list_end <= 1'b0;
      started <= 1'b0;
      base_dirty <= 1'b0;
      probe <= 1'b0;
      discard <= 1'b0;
      first_seg <= 1'b1;
      widx <= 2'h0;
      v <= 2'b00;
      boff <= 12'h000;
      flen <= 15'h0000;
      close_addr <= 32'h00000000;
      close_ls <= 1'b0;
      close_bad <= 1'b0;
      close_tn <= 1'b0;
      close_trunc <= 1'b0;
    end else if (mem_req && mem_ack && mem_err) begin
      mem_req <= 1'b0;
      ev_bf <= 1'b1;
      fsm_drop <= 1'b1;
      list_pos <= resume_pos;
      v <= 2'b00;
      discard <= 1'b0;
      first_seg <= 1'b1;
      boff <= 12'h000;
      flen <= 15'h0000;
      state <= erxic_pkg::RX_STOPPED;
    end else begin
      case (state)
        erxic_pkg::RX_STOPPED: begin
          if (start_reception) begin
            state <= erxic_pkg::RX_IDLE;
            list_end <= 1'b0;
            started <= 1'b1;
            base_dirty <= 1'b0;
            if (!started || base_dirty || rx_list_base_wr) begin
              list_pos <= rx_list_base;
            end
          end
        end
        erxic_pkg::RX_IDLE: begin
          if (!start_reception && !frame_busy) begin
            list_pos <= resume_pos;
            v <= 2'b00;
            first_seg <= 1'b1;
            state <= erxic_pkg::RX_STOPPED;
          end else if (discard) begin
            if (fifo_pop && fifo_out[erxic_pkg::FW_LAST]) begin
              discard <= 1'b0;
            end
          end else if (fifo_valid && fe_release && v[0]) begin
            state <= erxic_pkg::RX_WRITE;
          end else if (!v[0] && list_end) begin
            fsm_drop <= frame_busy;
            first_seg <= 1'b1;
            boff <= 12'h000;
            flen <= 15'h0000;
            ev_ru <= 1'b1;
            state <= erxic_pkg::RX_SUSPENDED;
          end else if (!v[1] && !list_end) begin
            widx <= 2'h0;
            probe <= 1'b0;
            state <= erxic_pkg::RX_FETCH;
          end
        end
        erxic_pkg::RX_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= list_pos + {28'h0000000, widx, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            widx <= widx + 2'h1;
            case (widx)
              2'h0: begin
                if (!mem_rdata[erxic_pkg::DW0_OWN]) begin
                  list_end <= 1'b1;
                  if (probe) begin
                    ev_missed <= 1'b1;
                    fsm_drop <= 1'b1;
                    state <= erxic_pkg::RX_SUSPENDED;
                  end else begin
                    state <= erxic_pkg::RX_IDLE;
                  end
                end
              end
              erxic_pkg::WIDX_CTL: begin
                f_size <= mem_rdata[erxic_pkg::DW1_SIZE_W-1:0];
                f_ca <= mem_rdata[erxic_pkg::DW1_CA];
              end
              erxic_pkg::WIDX_BUF: begin
                f_buf <= mem_rdata;
                f_tn <= mem_xlate_err;
              end
              default: begin
                list_pos <= f_ca ? mem_rdata : list_pos + erxic_pkg::DESC_STRIDE;
                list_end <= 1'b0;
                probe <= 1'b0;
                if (f_tn) begin
                  close_addr <= list_pos;
                  close_tn <= 1'b1;
                  state <= erxic_pkg::RX_CLOSE;
                end else begin
                  v[v[0] ? 1 : 0] <= 1'b1;
                  d_addr[v[0] ? 1 : 0] <= list_pos;
                  d_buf[v[0] ? 1 : 0] <= f_buf;
                  d_size[v[0] ? 1 : 0] <= f_size;
                  state <= erxic_pkg::RX_IDLE;
                end
              end
            endcase
          end
        end
        erxic_pkg::RX_WRITE: begin
          if (!mem_req) begin
            if (fifo_valid) begin
              mem_req <= 1'b1;
              mem_write <= 1'b1;
              mem_addr <= d_buf[0] + {20'h00000, boff};
              mem_wdata <= fifo_out[31:0];
            end
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            boff <= boff + erxic_pkg::WORD_BYTES;
            flen <= flen + {12'h000, fnb};
            if (fifo_out[erxic_pkg::FW_LAST] || boff + erxic_pkg::WORD_BYTES >= {1'b0, d_size[0]}) begin
              close_addr <= d_addr[0];
              close_ls <= fifo_out[erxic_pkg::FW_LAST] || chaining_disable;
              close_trunc <= !fifo_out[erxic_pkg::FW_LAST] && chaining_disable;
              close_bad <= fifo_out[erxic_pkg::FW_LAST] ? fifo_out[erxic_pkg::FW_BAD] : chaining_disable;
              close_tn <= 1'b0;
              state <= erxic_pkg::RX_CLOSE;
            end
          end
        end
        erxic_pkg::RX_CLOSE: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_write <= 1'b1;
            mem_addr <= close_addr;
            mem_wdata <= close_word;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            close_tn <= 1'b0;
            state <= erxic_pkg::RX_IDLE;
            if (!close_tn) begin
              v <= {1'b0, v[1]};
              d_addr[0] <= d_addr[1];
              d_buf[0] <= d_buf[1];
              d_size[0] <= d_size[1];
              boff <= 12'h000;
              discard <= close_trunc;
              first_seg <= close_ls;
              if (close_ls) begin
                ev_rx_done <= 1'b1;
                flen <= 15'h0000;
              end
            end
          end
        end
        erxic_pkg::RX_SUSPENDED: begin
          if (!start_reception) begin
            state <= erxic_pkg::RX_STOPPED;
          end else if (rx_poll_demand || fe_sof) begin
            list_end <= 1'b0;
            base_dirty <= 1'b0;
            if (base_dirty || rx_list_base_wr) begin
              list_pos <= rx_list_base;
            end
            widx <= 2'h0;
            probe <= !rx_poll_demand;
            state <= rx_poll_demand ? erxic_pkg::RX_IDLE : erxic_pkg::RX_FETCH;
          end
        end
        default: state <= erxic_pkg::RX_STOPPED;
      endcase
    end
  end

  // Status bits and interrupt request
  always_comb begin
    set_ev = '0;
    set_ev[erxic_pkg::ST_RI] = ev_rx_done;
    set_ev[erxic_pkg::ST_RU] = ev_ru;
    set_ev[erxic_pkg::ST_BF] = ev_bf;
    set_ev[erxic_pkg::ST_TI] = tx_done_event;
    next_status = (status_interrupt_register & ~status_clear) | set_ev;
    next_signalled = (irq_ack ? (signalled | status_interrupt_register) : signalled) & next_status;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      status_interrupt_register <= '0;
      signalled <= '0;
      irq_req <= 1'b0;
    end else begin
      status_interrupt_register <= next_status;
      signalled <= next_signalled;
      irq_req <= interrupt_enable_bit && |(next_status & ~next_signalled);
    end
  end

  // Missed frame counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      missed_frame_count <= 16'h0000;
    end else if (ev_missed && missed_frame_count != erxic_pkg::MFC_MAX) begin
      missed_frame_count <= missed_frame_count + 16'h0001;
    end
  end

  // Process state report
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_state <= erxic_pkg::RXS_STOPPED;
    end else begin
      case (state)
        erxic_pkg::RX_STOPPED: rx_state <= erxic_pkg::RXS_STOPPED;
        erxic_pkg::RX_SUSPENDED: rx_state <= erxic_pkg::RXS_SUSPENDED;
        erxic_pkg::RX_FETCH: rx_state <= probe ? erxic_pkg::RXS_SUSPENDED : erxic_pkg::RXS_RUNNING;
        default: rx_state <= erxic_pkg::RXS_RUNNING;
      endcase
    end
  end
endmodule

// ==== tb/erxic_checker.sv ====
// Assertion checker on the receive block ports
`timescale 1ns/10ps
module erxic_checker (
  // Clock and reset
  input logic mclk,
  input logic srst,
  // Control and status
  input logic interrupt_enable_bit,
  input logic start_reception,
  input logic irq_ack,
  input logic [erxic_pkg::ST_W-1:0] status_interrupt_register,
  input logic irq_req,
  input logic [1:0] rx_state,
  input logic [15:0] missed_frame_count,
  // Memory
  input logic mem_req,
  input logic mem_write,
  input logic [31:0] mem_addr,
  input logic mem_ack,
  input logic mem_err
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  irq_gate_a: assert property (irq_req |-> $past(interrupt_enable_bit))
    else $error("irq while disabled");
  ack_drop_a: assert property (irq_ack ##1 $stable(status_interrupt_register) |-> !irq_req)
    else $error("irq after ack");
  clear_drop_a: assert property ((status_interrupt_register == 4'h0) [*2] |-> !irq_req)
    else $error("irq without status");
  bus_stop_a: assert property (mem_ack && mem_err && rx_state == 2'h1 |->
    ##[1:4] rx_state == 2'h0 && status_interrupt_register[2]) else $error("no stop on bus fault");
  unavail_susp_a: assert property ($rose(status_interrupt_register[1]) |-> ##[0:3] rx_state == 2'h2)
    else $error("no suspend");
  susp_stop_a: assert property (rx_state == 2'h2 && !start_reception |-> ##[1:3] rx_state == 2'h0)
    else $error("slow stop");
  miss_step_a: assert property ($changed(missed_frame_count) |->
    missed_frame_count == $past(missed_frame_count) + 16'h0001 && $past(rx_state) == 2'h2) else $error("miss count");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("request dropped");
endmodule

// ==== tb/erxic_host_mem.sv ====
// Host memory model answering the block's memory requests
`timescale 1ns/10ps
module erxic_host_mem (
  // Clock
  input logic mclk,
  // Request
  input logic mem_req,
  input logic mem_write,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata,
  // Answer
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err,
  // Latency and fault control
  input logic [3:0] lat,
  input logic fail
);
  logic [31:0] mem [0:255];
  int cnt = 0;
  initial {mem_rdata, mem_ack, mem_err} = '0;
  always @(posedge mclk) begin
    #2;
    if (mem_ack) begin
      {mem_ack, mem_err} = 2'h0;
      mem_rdata = ~mem_rdata;
    end else if (mem_req && cnt < lat) begin
      cnt++;
    end else if (mem_req) begin
      cnt = 0;
      mem_ack = 1'b1;
      mem_err = fail;
      if (mem_write) mem[mem_addr[9:2]] = mem_wdata;
      else mem_rdata = mem[mem_addr[9:2]];
    end
  end
endmodule

// ==== tb/test_erxic_top.sv ====
// Self-checking bench for the receive and interrupt block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_erxic_top;
  logic mclk = 0, srst = 1, interrupt_enable_bit = 0, start_reception = 0, hash_filter_select = 0;
  logic pass_bad_frames = 0, chaining_disable = 0, rx_list_base_wr = 0, rx_poll_demand = 0, tx_done_event = 0;
  logic irq_ack = 0, rx_valid = 0, rx_end = 0, rx_err = 0, mem_xlate_err = 0, fail = 0;
  logic irq_req, mem_req, mem_write, mem_ack, mem_err;
  logic [1:0] filter_mode_field = 2'h0, rx_state;
  logic [3:0] lat = 4'h0, status_clear = 4'h0, status_interrupt_register;
  logic [7:0] rx_data = 8'h00;
  logic [15:0] missed_frame_count;
  logic [31:0] rx_list_base = 32'h0, mem_addr, mem_wdata, mem_rdata;
  logic [47:0] station_addr = 48'h000000000002;
  logic [511:0] mcast_hash_table = '0;
  int err_total = 0, n_compared = 0;
  erxic_top DUT (.*);
  erxic_host_mem mdl (.*);
  initial forever #12.5 mclk = ~mclk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic pulse(ref logic p);
    p = 1;
    tick();
    p = 0;
  endtask
  task automatic clr(input logic [3:0] v);
    status_clear = v;
    tick();
    status_clear = 4'h0;
    tick(2);
  endtask
  task automatic desc(input int i, input logic [31:0] w0, input logic [31:0] w2);
    mdl.mem[i] = w0;
    mdl.mem[i+1] = 32'h00000080;
    mdl.mem[i+2] = w2;
  endtask
  task automatic send(input int n, input logic e);
    for (int i = -3; i < n; i++) begin
      rx_valid = 1;
      rx_data = i < -1 ? 8'h55 : i < 0 ? erxic_pkg::SFD_BYTE : i < 6 ? station_addr[8*i+:8] : 8'(i);
      rx_end = i == n - 1;
      rx_err = e && rx_end;
      tick();
    end
    {rx_valid, rx_end, rx_err} = 3'h0;
    tick();
  endtask
  task automatic wt(input int b, input logic [1:0] s);
    int k;
    for (k = 0; k < 400; k++) begin
      if (b >= 0 ? status_interrupt_register[b] === 1'b1 : rx_state === s) break;
      tick();
    end
    if (k == 400) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mdl.mem[i] = 32'h0;
    tick(10);
    srst = 0;
    interrupt_enable_bit = 1;
    pulse(tx_done_event);
    tick(2);
    `CHK("irq", 1'b1, irq_req)
    pulse(tx_done_event);
    pulse(irq_ack);
    tick(2);
    `CHK("irq acked", 1'b0, irq_req)
    clr(4'h8);
    `CHK("status", 4'h0, status_interrupt_register)
    pulse(tx_done_event);
    tick(2);
    `CHK("irq again", 1'b1, irq_req)
    clr(4'h8);
    `CHK("irq withdrawn", 1'b0, irq_req)
    interrupt_enable_bit = 0;
    pulse(tx_done_event);
    tick(2);
    `CHK("irq masked", 1'b0, irq_req)
    clr(4'hF);
    $display("interrupt test done");
    hash_filter_select = 1;
    desc(16, 32'h80000000, 32'h00000100);
    desc(20, 32'h0, 32'h00000200);
    rx_list_base = 32'h00000040;
    pulse(rx_list_base_wr);
    start_reception = 1;
    tick(30);
    send(70, 0);
    wt(erxic_pkg::ST_RI, 2'h0);
    `CHK("buffer word", 32'h07060000, mdl.mem[65])
    `CHK("closed desc", 3'h3, {mdl.mem[16][31], mdl.mem[16][9:8]})
    wt(-1, erxic_pkg::RXS_SUSPENDED);
    `CHK("unavailable", 1'b1, status_interrupt_register[erxic_pkg::ST_RU])
    send(70, 0);
    tick(20);
    `CHK("missed", 16'h0001, missed_frame_count)
    $display("receive test done");
    start_reception = 0;
    wt(-1, erxic_pkg::RXS_STOPPED);
    desc(20, 32'h80000000, 32'h00000200);
    lat = 4'h3;
    start_reception = 1;
    tick(50);
    send(70, 0);
    wt(-1, erxic_pkg::RXS_SUSPENDED);
    `CHK("resumed buffer", 32'h07060000, mdl.mem[129])
    desc(24, 32'h80000000, 32'h00000300);
    desc(28, 32'h80000000, 32'h00000100);
    pulse(rx_poll_demand);
    wt(-1, erxic_pkg::RXS_RUNNING);
    clr(4'hF);
    filter_mode_field = 2'h3;
    send(70, 0);
    filter_mode_field = erxic_pkg::FM_NORMAL;
    send(20, 1);
    tick(40);
    `CHK("purged", 4'h0, status_interrupt_register)
    pass_bad_frames = 1;
    send(20, 0);
    wt(erxic_pkg::ST_RI, 2'h0);
    `CHK("runt kept", 32'h00148300, mdl.mem[24])
    fail = 1;
    send(70, 0);
    wt(erxic_pkg::ST_BF, 2'h0);
    wt(-1, erxic_pkg::RXS_STOPPED);
    $display("resume test done");
    finish_test();
  end
endmodule
bind erxic_top erxic_checker chk (.*);
